// *** core/dds_phase_core_control.sv ***
// Phase accumulator, offset adder, source selection, clearing and sweep of the synthesizer core
//
// Added by the designer: the strobed register port and the placing of the registers.
module dds_phase_core_control
    import dds_pkg::*;
#(
    parameter int unsigned ACC_W = 32,
    parameter int unsigned POW_W = 14,
    parameter int unsigned OUT_W = 19
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Pins from outside the clock domain
    input wire logic hw_reset,
    input wire logic io_update,
    input wire logic profile_select_low,
    input wire logic profile_select_high,
    // RAM output word, same clock
    input wire logic [31:0] ram_data,
    // Register bus
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Phase word to the cosine conversion
    output logic [OUT_W-1:0] phase_out,
    // Control levels to neighbouring blocks
    output logic osk_enable,
    output logic osk_auto_mode,
    output logic comparator_pd
);

    // Refuse widths the datapath cannot serve
    generate
        if (ACC_W > 32 || ACC_W < 2 || POW_W > OUT_W || OUT_W > ACC_W || POW_W < 1)
        begin : g_bad_width
            $error("dds_phase_core_control: unsupported width parameters");
        end
    endgenerate

    localparam int unsigned LOW_W = ACC_W - POW_W;

    // Clamped sweep step toward a limit, in either direction
    function automatic logic [ACC_W-1:0] step_to(
        input logic [ACC_W-1:0] cur,
        input logic [ACC_W-1:0] delta,
        input logic [ACC_W-1:0] lim,
        input logic up
    );
        logic [ACC_W:0] wide;
        wide = '0;
        if (up)
        begin
            wide = {1'b0, cur} + {1'b0, delta};
            step_to = (wide >= {1'b0, lim}) ? lim : wide[ACC_W-1:0];
        end
        else
        begin
            wide = {1'b0, lim} + {1'b0, delta};
            step_to = ({1'b0, cur} <= wide) ? lim : cur - delta;
        end
    endfunction

    // Implemented bits of each buffered register
    function automatic logic [31:0] reg_mask(input logic [2:0] idx);
        case (idx)
            IDX_SPO: reg_mask = MASK_SPO;
            IDX_RATE: reg_mask = MASK_RATE;
            default: reg_mask = MASK_FULL;
        endcase
    endfunction

    logic [3:0] sync_s1_q;
    logic [3:0] sync_s2_q;
    logic upd_pin_prev_q;
    logic [1:0] ps_prev_q;
    logic [2:0] warm_q;
    logic hw_rst;
    logic [1:0] ps_now;
    logic ps_change;
    logic upd_pin;
    logic upd_sw;
    logic upd;
    logic pins_armed;
    logic [31:0] buf_q [NUM_BUF];
    logic [31:0] act_q [NUM_BUF];
    logic [31:0] ctl1;
    logic [31:0] ctl1_next;
    logic ac_phase;
    logic ac_sweep;
    logic clr_phase;
    logic clr_sweep;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] ftw_sel;
    logic [POW_W-1:0] pow_sel;
    logic [POW_W-1:0] pow_dly_q;
    logic [ACC_W-1:0] sum_q;
    logic [ACC_W-1:0] freq_q;
    logic [RATE_W-1:0] timer_q;
    logic [RATE_W-1:0] rate_now;
    logic tick;
    logic dir_up;
    logic [ACC_W-1:0] step_val;
    sweep_state_t sw_state_q;
    logic [DATA_W-1:0] rdata_q;

    // Two-flop synchronisers for reset, update and profile pins
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_s1_q <= 4'h0;
            sync_s2_q <= 4'h0;
        end
        else
        begin
            sync_s1_q <= {profile_select_high, profile_select_low, io_update, hw_reset};
            sync_s2_q <= sync_s1_q;
        end
    end

    assign hw_rst = sync_s2_q[0];
    assign ps_now = sync_s2_q[3:2];

    // Edge memory for update pin and profile pins
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            upd_pin_prev_q <= 1'b0;
            ps_prev_q <= 2'h0;
            warm_q <= 3'h0;
        end
        else
        begin
            upd_pin_prev_q <= sync_s2_q[1];
            ps_prev_q <= ps_now;
            warm_q <= {warm_q[1:0], 1'b1}; // Full once the edge memory holds real pin levels
        end
    end

    // Transfer strobe: software, update pin rising edge or any profile change
    assign ps_change = (ps_now != ps_prev_q);
    assign upd_pin = sync_s2_q[1] & ~upd_pin_prev_q;
    assign upd_sw = reg_wr && (reg_addr == OFS_UPDATE);
    // A pin held high through reset would look like an edge once the synchroniser
    // fills and release the power-up clear early; pin changes in that window are lost
    assign pins_armed = warm_q[2];
    assign upd = (upd_sw | ((upd_pin | ps_change) & pins_armed)) & ~hw_rst;

    // Buffered registers written by software
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < NUM_BUF; i++)
            begin
                buf_q[i] <= REG_RST;
            end
            buf_q[IDX_CTL1] <= CTL1_BUF_RST;
        end
        else if (hw_rst)
        begin
            for (int i = 0; i < NUM_BUF; i++)
            begin
                buf_q[i] <= REG_RST;
            end
            buf_q[IDX_CTL1] <= CTL1_BUF_RST;
        end
        else if (reg_wr && !reg_addr[5] && (reg_addr[1:0] == 2'h0))
        begin
            buf_q[reg_addr[4:2]] <= reg_wdata & reg_mask(reg_addr[4:2]);
        end
    end

    // Active registers, loaded as a set on each transfer strobe
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < NUM_BUF; i++)
            begin
                act_q[i] <= REG_RST;
            end
            act_q[IDX_CTL1] <= CTL1_ACT_RST;
        end
        else if (hw_rst)
        begin
            for (int i = 0; i < NUM_BUF; i++)
            begin
                act_q[i] <= REG_RST;
            end
            act_q[IDX_CTL1] <= CTL1_ACT_RST;
        end
        else if (upd)
        begin
            for (int i = 0; i < NUM_BUF; i++)
            begin
                act_q[i] <= buf_q[i];
            end
        end
    end

    assign ctl1 = act_q[IDX_CTL1];
    assign ctl1_next = buf_q[IDX_CTL1];

    // Auto-clear uses the value being transferred, so a freshly set bit acts at once
    assign ac_phase = upd & ctl1_next[B_AUTO_PHASE];
    assign ac_sweep = upd & ctl1_next[B_AUTO_SWEEP];
    // Each accumulator has its own clear path, so the two modes mix freely
    assign clr_phase = ctl1[B_CLR_PHASE] | ac_phase;
    assign clr_sweep = ctl1[B_CLR_SWEEP] | ac_sweep;

    // Tuning word source: RAM, then sweep, then static register
    always_comb
    begin
        if (ctl1[B_RAM_EN] && !ctl1[B_RAM_DEST])
        begin
            ftw_sel = ram_data[ACC_W-1:0];
        end
        else if (ctl1[B_SWEEP_EN])
        begin
            ftw_sel = freq_q;
        end
        else
        begin
            ftw_sel = act_q[IDX_STW][ACC_W-1:0];
        end
    end

    // Phase offset source: top RAM bits when RAM drives phase, else static register
    always_comb
    begin
        if (ctl1[B_RAM_EN] && ctl1[B_RAM_DEST])
        begin
            pow_sel = ram_data[31 -: POW_W];
        end
        else
        begin
            pow_sel = act_q[IDX_SPO][POW_W-1:0];
        end
    end

    // Phase accumulator wraps modulo 2^ACC_W; words above half give the mirrored tone
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_q <= '0;
        end
        else if (hw_rst || clr_phase)
        begin
            acc_q <= '0;
        end
        else
        begin
            acc_q <= acc_q + ftw_sel;
        end
    end

    // Offset delay matches the one cycle a new tuning word needs to reach the accumulator
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pow_dly_q <= '0;
            sum_q <= '0;
        end
        else if (hw_rst)
        begin
            pow_dly_q <= '0;
            sum_q <= '0;
        end
        else
        begin
            pow_dly_q <= pow_sel;
            sum_q <= acc_q + {pow_dly_q, {LOW_W{1'b0}}};
        end
    end

    // Only the top bits go on; dropping the rest saves power, not frequency resolution
    assign phase_out = sum_q[ACC_W-1 -: OUT_W];

    // Sweep direction follows the low profile pin: high sweeps up
    assign dir_up = ps_now[0];
    assign rate_now = dir_up ? act_q[IDX_RATE][RATE_RISE_LSB +: RATE_W]
                             : act_q[IDX_RATE][RATE_FALL_LSB +: RATE_W];
    assign tick = (timer_q <= {{(RATE_W-1){1'b0}}, 1'b1});
    assign step_val = dir_up
        ? step_to(freq_q, act_q[IDX_RISE][ACC_W-1:0], act_q[IDX_TERM][ACC_W-1:0], 1'b1)
        : step_to(freq_q, act_q[IDX_FALL][ACC_W-1:0], act_q[IDX_START][ACC_W-1:0], 1'b0);

    // Linear sweep: ramp timer paces steps; steps clamp at the limits, so a sane
    // program cannot wrap, but limits reversed by the host give no useful sweep
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sw_state_q <= SW_IDLE;
            freq_q <= '0;
            timer_q <= '0;
        end
        else if (hw_rst)
        begin
            sw_state_q <= SW_IDLE;
            freq_q <= '0;
            timer_q <= '0;
        end
        else
        begin
            case (sw_state_q)
                SW_IDLE:
                begin
                    freq_q <= act_q[IDX_START][ACC_W-1:0];
                    timer_q <= rate_now;
                    if (ctl1[B_SWEEP_EN])
                    begin
                        sw_state_q <= SW_RUN;
                    end
                end
                SW_RUN:
                begin
                    if (!ctl1[B_SWEEP_EN])
                    begin
                        sw_state_q <= SW_IDLE;
                    end
                    else if (clr_sweep)
                    begin
                        freq_q <= act_q[IDX_START][ACC_W-1:0];
                        timer_q <= rate_now;
                    end
                    else if (tick)
                    begin
                        timer_q <= rate_now;
                        if (dir_up && ctl1[B_NO_DWELL] && (step_val == act_q[IDX_TERM][ACC_W-1:0]))
                        begin
                            freq_q <= act_q[IDX_START][ACC_W-1:0];
                        end
                        else
                        begin
                            freq_q <= step_val;
                        end
                    end
                    else
                    begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                default:
                begin
                    sw_state_q <= SW_IDLE;
                end
            endcase
        end
    end

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_q <= '0;
        end
        else if (reg_rd)
        begin
            if (!reg_addr[5] && (reg_addr[1:0] == 2'h0))
            begin
                rdata_q <= buf_q[reg_addr[4:2]];
            end
            else if (reg_addr == OFS_PHASE)
            begin
                rdata_q <= 32'(acc_q);
            end
            else if (reg_addr == OFS_FREQ)
            begin
                rdata_q <= 32'(freq_q);
            end
            else
            begin
                rdata_q <= '0; // Unmapped reads as zero
            end
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

    // Control levels straight from the active register
    assign osk_enable = ctl1[B_OSK_EN];
    assign osk_auto_mode = ctl1[B_OSK_AUTO];
    assign comparator_pd = ctl1[B_COMP_PD];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_auto_phase_upd;
        upd && ctl1_next[B_AUTO_PHASE] && !hw_rst;
    endsequence

    sequence s_cleared_then_runs;
        (acc_q == '0) ##1 ($past(hw_rst) || $past(clr_phase) || acc_q == $past(ftw_sel));
    endsequence

    a_acc_adds_word: assert property (
        !hw_rst && !clr_phase |=> acc_q == $past(acc_q) + $past(ftw_sel))
        else $error("phase accumulator did not add tuning word");

    a_output_top_bits: assert property (
        !hw_rst ##1 !hw_rst |=>
        phase_out == OUT_W'(($past(acc_q) + {$past(pow_sel, 2), {LOW_W{1'b0}}}) >> (ACC_W - OUT_W)))
        else $error("phase output not truncated sum of delayed offset");

    a_zero_word_holds: assert property (
        ftw_sel == '0 && !clr_phase && !hw_rst |=> $stable(acc_q))
        else $error("zero tuning word moved the phase");

    a_clear_forces_zero: assert property (
        ctl1[B_CLR_PHASE] [*2] |-> acc_q == '0)
        else $error("clear bit did not hold accumulator at zero");

    a_transfer_copies: assert property (
        upd |=> ctl1 == $past(ctl1_next) && act_q[IDX_STW] == $past(buf_q[IDX_STW]))
        else $error("transfer strobe did not copy buffers");

    a_static_word_used: assert property (
        !ctl1[B_RAM_EN] && !ctl1[B_SWEEP_EN] |-> ftw_sel == act_q[IDX_STW][ACC_W-1:0])
        else $error("static tuning word not selected");

    a_auto_clear_once: assert property (
        s_auto_phase_upd |=> s_cleared_then_runs)
        else $error("auto clear did not clear once and release");

    a_profile_strobes: assert property (
        pins_armed && !hw_rst && $changed(ps_now) |-> upd ##1 (ctl1 == $past(ctl1_next)))
        else $error("profile change gave no transfer strobe");

    a_hw_reset_defaults: assert property (
        hw_rst |=> acc_q == '0 && ctl1 == CTL1_ACT_RST && ctl1_next == CTL1_BUF_RST)
        else $error("hardware reset did not restore defaults");

endmodule

// *** core/dds_pkg.sv ***
// Shared offsets, field positions, reset values and state codes of the phase core
package dds_pkg;
    // Register bus geometry
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_BUF = 8;
    // Index of each buffered register; byte offset is four times the index
    localparam logic [2:0] IDX_CTL1 = 3'h0;
    localparam logic [2:0] IDX_STW = 3'h1;
    localparam logic [2:0] IDX_SPO = 3'h2;
    localparam logic [2:0] IDX_START = 3'h3;
    localparam logic [2:0] IDX_TERM = 3'h4;
    localparam logic [2:0] IDX_RISE = 3'h5;
    localparam logic [2:0] IDX_FALL = 3'h6;
    localparam logic [2:0] IDX_RATE = 3'h7;
    // Byte offsets of the non-buffered locations
    localparam logic [5:0] OFS_UPDATE = 6'h20;
    localparam logic [5:0] OFS_PHASE = 6'h24;
    localparam logic [5:0] OFS_FREQ = 6'h28;
    // Field positions inside first_control_register
    localparam int unsigned B_RAM_EN = 31;
    localparam int unsigned B_RAM_DEST = 30;
    localparam int unsigned B_OSK_EN = 25;
    localparam int unsigned B_OSK_AUTO = 24;
    localparam int unsigned B_SWEEP_EN = 21;
    localparam int unsigned B_AUTO_SWEEP = 14;
    localparam int unsigned B_AUTO_PHASE = 13;
    localparam int unsigned B_CLR_SWEEP = 11;
    localparam int unsigned B_CLR_PHASE = 10;
    localparam int unsigned B_COMP_PD = 6;
    localparam int unsigned B_NO_DWELL = 2;
    // Ramp rate register fields
    localparam int unsigned RATE_W = 8;
    localparam int unsigned RATE_RISE_LSB = 0;
    localparam int unsigned RATE_FALL_LSB = 8;
    // Implemented bits of the narrow registers
    localparam logic [31:0] MASK_SPO = 32'h0000_3fff;
    localparam logic [31:0] MASK_RATE = 32'h0000_ffff;
    localparam logic [31:0] MASK_FULL = 32'hffff_ffff;
    // Reset values: active clear-phase bit set, its buffer clear
    localparam logic [31:0] CTL1_ACT_RST = 32'h0000_0400;
    localparam logic [31:0] CTL1_BUF_RST = 32'h0000_0000;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    // Sweep controller states
    typedef enum logic [1:0] {
        SW_IDLE = 2'b01,
        SW_RUN = 2'b10
    } sweep_state_t;
endpackage

// *** tb/dds_ram_model.sv ***
// Synchronous RAM read port model that feeds words to the tuning and offset selectors
module dds_ram_model
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Word chosen by the bench
    input wire logic load,
    input wire logic [31:0] load_word,
    // Word to the core
    output logic [31:0] ram_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // Registered like a real read port; reset shows a busy pattern so a zero word is never assumed
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            ram_data <= 32'h5a5a_a5a5;
        else if (load)
            ram_data <= load_word;
    end
endmodule

// *** tb/dds_phase_core_control_tb_top.sv ***
// Self-checking bench of the phase core: bus tasks, one task per scenario, verdict
module dds_phase_core_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dds_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hw_reset = 1'b0;
    logic io_update = 1'b0;
    logic profile_select_low = 1'b1;
    logic profile_select_high = 1'b0;
    logic [31:0] ram_data;
    logic ram_load = 1'b0;
    logic [31:0] ram_word = 32'h0;
    logic [5:0] reg_addr = 6'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [18:0] phase_out;
    logic osk_enable;
    logic osk_auto_mode;
    logic comparator_pd;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [31:0] v1;
    logic [31:0] v2;

    // Clock at 100 MHz
    always #5 core_clk = ~core_clk;

    dds_phase_core_control dds_phase_core_control_inst (
        .core_clk(core_clk), .reset_n(reset_n), .hw_reset(hw_reset), .io_update(io_update),
        .profile_select_low(profile_select_low), .profile_select_high(profile_select_high),
        .ram_data(ram_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_out(phase_out), .osk_enable(osk_enable),
        .osk_auto_mode(osk_auto_mode), .comparator_pd(comparator_pd));

    dds_ram_model dds_ram_model_inst (
        .core_clk(core_clk), .reset_n(reset_n), .load(ram_load), .load_word(ram_word),
        .ram_data(ram_data));

    // Byte offset of a buffered register
    function automatic logic [5:0] ofs(input logic [2:0] i);
        return {1'b0, i, 2'b00};
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One-cycle write strobe; released at the next edge
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is taken there
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic xfer();
        wr(OFS_UPDATE, 32'h0);
        repeat (6) @(posedge core_clk);
    endtask

    task automatic t_reset_values();
        rd(ofs(IDX_CTL1), v1);
        chk("ctl1 buffer", 32'h0, v1);
        rd(OFS_PHASE, v1);
        chk("acc held clear", 32'h0, v1);
        #1 chk("outputs", 32'h0, {phase_out, osk_enable, osk_auto_mode, comparator_pd});
    endtask

    // Two reads two cycles apart differ by twice the active word
    task automatic t_static_word();
        wr(ofs(IDX_STW), 32'h1000_0001);
        xfer();
        rd(OFS_PHASE, v1);
        rd(OFS_PHASE, v2);
        chk("acc step", 32'h2000_0002, v2 - v1);
        wr(ofs(IDX_STW), 32'h0);
        xfer();
        rd(OFS_PHASE, v1);
        rd(OFS_PHASE, v2);
        chk("zero word holds", v1, v2);
    endtask

    task automatic t_offset();
        wr(ofs(IDX_CTL1), 32'h1 << B_CLR_PHASE);
        wr(ofs(IDX_SPO), 32'h0000_2000);
        xfer();
        rd(OFS_PHASE, v1);
        chk("cleared acc", 32'h0, v1);
        chk("half turn offset", 32'h0004_0000, {13'h0, phase_out});
        wr(ofs(IDX_SPO), 32'h0000_0001);
        xfer();
        chk("smallest offset", 32'h0000_0020, {13'h0, phase_out});
    endtask

    // Offset from the RAM word top bits, then tuning word from the RAM word
    task automatic t_ram_source();
        @(posedge core_clk);
        ram_load <= 1'b1;
        ram_word <= 32'h0004_0000;
        @(posedge core_clk);
        ram_load <= 1'b0;
        wr(ofs(IDX_CTL1), (32'h3 << B_RAM_DEST) | (32'h1 << B_CLR_PHASE));
        xfer();
        chk("ram offset", 32'h0000_0020, {13'h0, phase_out});
        wr(ofs(IDX_CTL1), 32'h1 << B_RAM_EN);
        xfer();
        rd(OFS_PHASE, v1);
        rd(OFS_PHASE, v2);
        chk("ram word step", 32'h0008_0000, v2 - v1);
    endtask

    // Each strobe with auto-clear set restarts the phase accumulator
    task automatic t_auto_clear();
        wr(ofs(IDX_STW), 32'h0000_0100);
        wr(ofs(IDX_CTL1), (32'h1 << B_AUTO_PHASE) | (32'h1 << B_CLR_SWEEP));
        xfer();
        repeat (40) @(posedge core_clk);
        rd(OFS_PHASE, v1);
        xfer();
        rd(OFS_PHASE, v2);
        chk("auto clear", 32'h1, (v1 > 32'h1000) && (v2 < 32'h0000_0a00));
        rd(OFS_PHASE, v1);
        chk("resumes", 32'h0000_0200, v1 - v2);
    endtask

    // Upward sweep; limits far apart so the sampled steps never reach the terminal clamp
    task automatic t_sweep();
        wr(ofs(IDX_START), 32'h0000_0100);
        wr(ofs(IDX_TERM), 32'h0010_0000);
        wr(ofs(IDX_RISE), 32'h0000_0010);
        wr(ofs(IDX_RATE), 32'h0000_0101);
        wr(ofs(IDX_CTL1), 32'h1 << B_SWEEP_EN);
        xfer();
        rd(OFS_FREQ, v1);
        rd(OFS_FREQ, v2);
        chk("sweep step", 32'h0000_0020, v2 - v1);
        chk("sweep in range", 32'h1, (v1 > 32'h100) && (v2 < 32'h0010_0000));
        // Near terminal: without no-dwell the sweep parks there, with it the sweep restarts
        wr(ofs(IDX_TERM), 32'h0000_0140);
        xfer();
        rd(OFS_FREQ, v1);
        chk("sweep dwells at terminal", 32'h0000_0140, v1);
        wr(ofs(IDX_CTL1), (32'h1 << B_SWEEP_EN) | (32'h1 << B_NO_DWELL));
        xfer();
        rd(OFS_FREQ, v1);
        rd(OFS_FREQ, v2);
        chk("no dwell restarts", 32'h1, (v1 < 32'h140) && (v2 < 32'h140) && (v1 >= 32'h100));
    endtask

    // Control levels move only when the buffer is transferred
    task automatic t_control_bits();
        wr(ofs(IDX_CTL1), 32'h0300_0040);
        #1 chk("buffered only", 32'h0, {osk_enable, osk_auto_mode, comparator_pd});
        xfer();
        chk("keying and comparator", 32'h7, {osk_enable, osk_auto_mode, comparator_pd});
        rd(ofs(IDX_CTL1), v1);
        chk("ctl1 readback", 32'h0300_0040, v1);
        rd(6'h2c, v1);
        chk("unmapped read", 32'h0, v1);
        wr(ofs(IDX_CTL1), 32'h0200_0000);
        xfer();
        chk("manual keying", 32'h4, {osk_enable, osk_auto_mode, comparator_pd});
    endtask

    // A profile pin change and an update pin edge both act as a transfer
    task automatic t_pins();
        wr(ofs(IDX_CTL1), 32'h1 << B_COMP_PD);
        repeat (4) @(posedge core_clk);
        profile_select_high <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("profile change", 32'h1, comparator_pd);
        wr(ofs(IDX_CTL1), 32'h0);
        io_update <= 1'b1;
        repeat (6) @(posedge core_clk);
        io_update <= 1'b0;
        chk("update pin", 32'h0, comparator_pd);
    endtask

    task automatic t_hw_reset();
        wr(ofs(IDX_CTL1), 32'h0200_0040);
        xfer();
        hw_reset <= 1'b1;
        repeat (5) @(posedge core_clk);
        hw_reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("pin reset levels", 32'h0, {osk_enable, comparator_pd});
        rd(ofs(IDX_CTL1), v1);
        chk("pin reset buffer", 32'h0, v1);
        rd(OFS_PHASE, v1);
        chk("pin reset acc", 32'h0, v1);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the scenarios take
    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset_values();
        t_static_word();
        t_offset();
        t_ram_source();
        t_auto_clear();
        t_sweep();
        t_control_bits();
        t_pins();
        t_hw_reset();
        close_out();
    end
endmodule
